// >>> core/dis_pkg.sv
// Purpose: Constants for the dual integrator conversion sequencer
// Assumes: mclk at 10 MHz; internal clock is mclk or mclk divided by four
// Notes:   Times are in ns; cycle counts are in internal clock periods
`default_nettype none
package dis_pkg;
    localparam int unsigned MCLK_HZ        = 10_000_000;
    localparam int unsigned INT_FAST_HZ    = 10_000_000;
    localparam int unsigned DIV_RATIO      = 4;
    // Data-ready delay in ns at the fast internal clock (half of 276400)
    localparam int unsigned T_DR_FAST_NS   = 138_200;
    localparam int unsigned DR_TICKS       = T_DR_FAST_NS / (1_000_000_000 / INT_FAST_HZ);
    // Minimum integration at 10 MHz internal clock
    localparam int unsigned T_MIN_INT_NS   = 160_000;
    localparam int unsigned MIN_INT_TICKS  =
        (T_MIN_INT_NS + (1_000_000_000 / INT_FAST_HZ) - 1) / (1_000_000_000 / INT_FAST_HZ);
    localparam int unsigned RECOV_TICKS    = 5000;
    localparam int unsigned RECOV_COUNT    = 3;
    localparam int unsigned CNT_W          = 16;
    // Converter busy time and capacitor precharge time, internal periods
    localparam int unsigned INTEGRATE_TOGGLE_TICKS     = 1000;
    localparam int unsigned PRECH_TICKS    = 100;
    // Configuration register layout
    localparam int unsigned CFG_W          = 16;
    localparam int unsigned CFG_CLKDIV_BIT = 13;
    localparam int unsigned CFG_RANGE_LSB  = 8;
    localparam logic [15:0] CFG_RESET      = 16'h0000;

    typedef enum logic [1:0] {
        DIS_RANGE_3PF  = 2'h0,
        DIS_RANGE_12P5 = 2'h1,
        DIS_RANGE_25PF = 2'h2,
        DIS_RANGE_37P5 = 2'h3
    } dis_range_t;

    // One-hot side phases
    typedef enum logic [3:0] {
        DIS_INTEG = 4'h1,
        DIS_INTEGRATE_TOGGLE  = 4'h2,
        DIS_PRECH = 4'h4,
        DIS_WAIT  = 4'h8
    } dis_phase_t;
endpackage
`default_nettype wire

// >>> core/dis_side_if.sv
// Purpose: Carries per-side phase and timing between sequencer and side
// Assumes: One clock domain
// Notes:   Timer ticks are internal clock enables
`default_nettype none
interface dis_side_if;
    logic                    tick;
    logic                    start_int;
    logic                    stop_int;
    dis_pkg::dis_phase_t     phase;
    modport ctrl (output tick, output start_int, output stop_int, input phase);
    modport side (input tick, input start_int, input stop_int, output phase);
endinterface
`default_nettype wire

// >>> core/dis_side.sv
// Purpose: Phase sequencer of one integrator side
// Assumes: Start and stop are one-cycle pulses on toggle edges
// Notes:   Convert, precharge, then wait until the next start
`default_nettype none
module dis_side (
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst_n,
    // Control
    dis_side_if.side   sif
);
    logic [dis_pkg::CNT_W-1:0] cnt_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sif.phase <= dis_pkg::DIS_WAIT;
            cnt_reg   <= '0;
        end else if (sif.start_int) begin
            sif.phase <= dis_pkg::DIS_INTEG;
            cnt_reg   <= '0;
        end else begin
            case (sif.phase)
                dis_pkg::DIS_INTEG: begin
                    if (sif.stop_int) begin
                        sif.phase <= dis_pkg::DIS_INTEGRATE_TOGGLE;
                        cnt_reg   <= '0;
                    end
                end
                dis_pkg::DIS_INTEGRATE_TOGGLE: begin
                    if (sif.tick) begin
                        if (cnt_reg == dis_pkg::CNT_W'(dis_pkg::INTEGRATE_TOGGLE_TICKS - 1)) begin
                            sif.phase <= dis_pkg::DIS_PRECH;
                            cnt_reg   <= '0;
                        end else begin
                            cnt_reg <= cnt_reg + 1'b1;
                        end
                    end
                end
                dis_pkg::DIS_PRECH: begin
                    if (sif.tick) begin
                        if (cnt_reg == dis_pkg::CNT_W'(dis_pkg::PRECH_TICKS - 1)) begin
                            sif.phase <= dis_pkg::DIS_WAIT;
                            cnt_reg   <= '0;
                        end else begin
                            cnt_reg <= cnt_reg + 1'b1;
                        end
                    end
                end
                default: begin
                    sif.phase <= dis_pkg::DIS_WAIT;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> core/dis_seq.sv
// Purpose: Dual integrator conversion sequencer top
// Assumes: Toggle, shift clock and config port come from pins
// Notes:   Switch controls are levels applied to all 64 channels at once
`default_nettype none
module dis_seq #(
    parameter int unsigned DR_TICKS    = dis_pkg::DR_TICKS,
    parameter int unsigned MIN_TICKS   = dis_pkg::MIN_INT_TICKS,
    parameter int unsigned RECOV_TICKS = dis_pkg::RECOV_TICKS
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Conversion control
    input  wire logic        integrate_toggle,
    input  wire logic        shift_clock,
    // Configuration port
    input  wire logic        cfg_data,
    input  wire logic        cfg_clock,
    // Front end controls
    output logic             int_a,
    output logic             int_b,
    output logic             integrate_toggle_a,
    output logic             integrate_toggle_b,
    output logic             prech_a,
    output logic             prech_b,
    output logic [1:0]       cap_range,
    output logic             suspended,
    // Status
    output logic             data_ready_n
);
    logic [1:0]                rst_sync_reg;
    logic                      rst_n;
    logic [1:0]                tog_sync_reg;
    logic                      tog_reg;
    logic [1:0]                sck_sync_reg;
    logic                      sck_reg;
    logic [1:0]                ccl_sync_reg;
    logic                      ccl_reg;
    logic [1:0]                cdt_sync_reg;
    logic [dis_pkg::CFG_W-1:0] cfg_reg;
    logic [1:0]                div_reg;
    logic                      tick;
    logic                      rise;
    logic                      fall;
    logic                      edge_any;
    logic [dis_pkg::CNT_W-1:0] int_cnt_reg;
    logic [dis_pkg::CNT_W-1:0] dr_cnt_reg;
    logic                      dr_run_reg;
    logic                      susp_reg;
    logic [1:0]                recov_reg;
    logic                      sck_hi_reg;
    logic                      started_reg;
    dis_side_if                sa ();
    dis_side_if                sb ();

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Pin synchronisers; the delayed copies feed edge detection
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tog_sync_reg <= 2'h0;
            tog_reg      <= 1'b0;
            sck_sync_reg <= 2'h0;
            sck_reg      <= 1'b0;
            ccl_sync_reg <= 2'h0;
            ccl_reg      <= 1'b0;
            cdt_sync_reg <= 2'h0;
        end else begin
            tog_sync_reg <= {tog_sync_reg[0], integrate_toggle};
            tog_reg      <= tog_sync_reg[1];
            sck_sync_reg <= {sck_sync_reg[0], shift_clock};
            sck_reg      <= sck_sync_reg[1];
            ccl_sync_reg <= {ccl_sync_reg[0], cfg_clock};
            ccl_reg      <= ccl_sync_reg[1];
            cdt_sync_reg <= {cdt_sync_reg[0], cfg_data};
        end
    end

    assign rise     = tog_sync_reg[1] & ~tog_reg;
    assign fall     = ~tog_sync_reg[1] & tog_reg;
    assign edge_any = rise | fall;

    // Config shift register, MSB first on cfg clock rising edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= dis_pkg::CFG_RESET;
        end else if (ccl_sync_reg[1] & ~ccl_reg) begin
            cfg_reg <= {cfg_reg[dis_pkg::CFG_W-2:0], cdt_sync_reg[1]};
        end
    end

    // Common range for every integrator
    assign cap_range = cfg_reg[dis_pkg::CFG_RANGE_LSB +: 2];

    // Internal clock enable: every cycle or one in four
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
        end
    end
    assign tick = cfg_reg[dis_pkg::CFG_CLKDIV_BIT] ? 1'b1 : (div_reg == 2'h3);

    // Integration length in internal periods, restarted at every edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            int_cnt_reg <= '0;
        end else if (edge_any) begin
            int_cnt_reg <= '0;
        end else if (tick && int_cnt_reg != '1) begin
            int_cnt_reg <= int_cnt_reg + 1'b1;
        end
    end

    // Minimum-time check and three-integration recovery
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            susp_reg    <= 1'b0;
            recov_reg   <= 2'h0;
            started_reg <= 1'b0;
        end else if (edge_any) begin
            started_reg <= 1'b1;
            if (started_reg && int_cnt_reg < dis_pkg::CNT_W'(MIN_TICKS)) begin
                susp_reg  <= 1'b1;
                recov_reg <= 2'h0;
            end else if (susp_reg) begin
                if (started_reg && int_cnt_reg >= dis_pkg::CNT_W'(RECOV_TICKS)) begin
                    if (recov_reg == 2'(dis_pkg::RECOV_COUNT - 1)) begin
                        susp_reg  <= 1'b0;
                        recov_reg <= 2'h0;
                    end else begin
                        recov_reg <= recov_reg + 2'h1;
                    end
                end else begin
                    recov_reg <= 2'h0;
                end
            end
        end
    end
    assign suspended = susp_reg;

    // Side sequencing
    assign sa.tick      = tick;
    assign sb.tick      = tick;
    assign sa.start_int = rise & ~susp_reg;
    assign sa.stop_int  = fall;
    assign sb.start_int = fall & ~susp_reg;
    assign sb.stop_int  = rise;

    dis_side u_side_a (
        .clk   (mclk),
        .rst_n (rst_n),
        .sif   (sa)
    );
    dis_side u_side_b (
        .clk   (mclk),
        .rst_n (rst_n),
        .sif   (sb)
    );

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            int_a   <= 1'b0;
            int_b   <= 1'b0;
            integrate_toggle_a  <= 1'b0;
            integrate_toggle_b  <= 1'b0;
            prech_a <= 1'b0;
            prech_b <= 1'b0;
        end else begin
            int_a   <= (sa.phase == dis_pkg::DIS_INTEG);
            int_b   <= (sb.phase == dis_pkg::DIS_INTEG);
            integrate_toggle_a  <= (sa.phase == dis_pkg::DIS_INTEGRATE_TOGGLE);
            integrate_toggle_b  <= (sb.phase == dis_pkg::DIS_INTEGRATE_TOGGLE);
            prech_a <= (sa.phase == dis_pkg::DIS_PRECH);
            prech_b <= (sb.phase == dis_pkg::DIS_PRECH);
        end
    end

    // Data-ready delay timer, in internal periods from the edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dr_cnt_reg <= '0;
            dr_run_reg <= 1'b0;
        end else if (edge_any && started_reg) begin
            dr_cnt_reg <= '0;
            dr_run_reg <= 1'b1;
        end else if (dr_run_reg && tick) begin
            if (dr_cnt_reg == dis_pkg::CNT_W'(DR_TICKS - 1)) begin
                dr_run_reg <= 1'b0;
            end else begin
                dr_cnt_reg <= dr_cnt_reg + 1'b1;
            end
        end
    end

    // Low on ready; high after shift clock goes high then low
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            data_ready_n <= 1'b1;
            sck_hi_reg   <= 1'b0;
        end else if (dr_run_reg && tick && dr_cnt_reg == dis_pkg::CNT_W'(DR_TICKS - 1)) begin
            data_ready_n <= 1'b0;
            sck_hi_reg   <= 1'b0;
        end else if (!data_ready_n) begin
            if (sck_sync_reg[1] & ~sck_reg) begin
                sck_hi_reg <= 1'b1;
            end else if (sck_hi_reg && !sck_sync_reg[1] && sck_reg) begin
                data_ready_n <= 1'b1;
                sck_hi_reg   <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verification/dis_seq_properties.sv
// Purpose: Port-level assertions for the conversion sequencer
// Assumes: Delay and gap checks hold only with the fast internal tick
// Notes:   Helpers track toggle gaps, config bits and readout progress
`default_nettype none
module dis_seq_properties #(
    parameter int unsigned DR_TICKS    = 20,
    parameter int unsigned MIN_TICKS   = 10,
    parameter int unsigned RECOV_TICKS = 30
) (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       nrst,
    // Pins
    input wire logic       integrate_toggle,
    input wire logic       shift_clock,
    input wire logic       cfg_data,
    input wire logic       cfg_clock,
    // Outputs
    input wire logic       int_a,
    input wire logic       int_b,
    input wire logic       integrate_toggle_a,
    input wire logic       integrate_toggle_b,
    input wire logic       prech_a,
    input wire logic       prech_b,
    input wire logic [1:0] cap_range,
    input wire logic       suspended,
    input wire logic       data_ready_n
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DR_LO  = DR_TICKS;
    localparam int DR_HI  = DR_TICKS + 16;
    localparam int MIN_LO = MIN_TICKS - 2;
    localparam int MIN_HI = MIN_TICKS + 3;
    logic [15:0] gap_reg;
    logic [15:0] cfg_reg;
    logic        seen_reg;
    logic        hi_reg;
    logic        sus_reg;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            gap_reg  <= 16'hffff;
            seen_reg <= 1'b0;
        end else if ($changed(integrate_toggle)) begin
            gap_reg  <= 16'h0000;
            seen_reg <= 1'b1;
        end else if (gap_reg != 16'hffff) begin
            gap_reg <= gap_reg + 16'h0001;
        end
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cfg_reg <= 16'h0000;
            hi_reg  <= 1'b0;
            sus_reg <= 1'b0;
        end else begin
            if ($rose(cfg_clock)) cfg_reg <= {cfg_reg[14:0], cfg_data};
            hi_reg  <= !data_ready_n && (hi_reg || shift_clock);
            sus_reg <= sus_reg || suspended;
        end
    end
    side_phase_a: assert property ($onehot0({int_a, integrate_toggle_a, prech_a}))
        else $error("side A in two phases");
    handover_a: assert property ($fell(int_a) && !suspended |-> int_b && integrate_toggle_a)
        else $error("side A stop without B start and convert");
    handover_b_a: assert property ($fell(int_b) && !suspended |-> int_a && integrate_toggle_b)
        else $error("side B stop without A start and convert");
    prech_after_integrate_toggle_a: assert property ($fell(integrate_toggle_a) && !suspended |-> prech_a)
        else $error("no precharge after convert");
    prech_integrate_toggle_b_a: assert property ($fell(integrate_toggle_b) && !suspended |-> prech_b)
        else $error("no side B precharge after convert");
    prech_hold_a: assert property ($rose(prech_a) |-> prech_a[*8])
        else $error("precharge too short");
    start_a: assert property ($rose(integrate_toggle) && !suspended
        && gap_reg > MIN_HI |-> ##[2:10] int_a)
        else $error("side A did not start");
    fall_switch_a: assert property ($fell(integrate_toggle) && int_a && !suspended
        && gap_reg > MIN_HI |-> ##[2:10] (int_b && !int_a))
        else $error("no switch to side B");
    ready_delay_a: assert property ($changed(integrate_toggle) && seen_reg
        && data_ready_n && cfg_reg[13] && !sus_reg |-> ##[DR_LO:DR_HI] !data_ready_n)
        else $error("data ready late or missing");
    ready_hold_a: assert property ($rose(data_ready_n) |-> hi_reg)
        else $error("data ready released without shift clock");
    ready_release_a: assert property (hi_reg && $fell(shift_clock)
        |-> ##[1:8] data_ready_n)
        else $error("data ready not released");
    short_gap_a: assert property ($changed(integrate_toggle) && seen_reg
        && cfg_reg[13] && gap_reg < MIN_LO |-> ##[3:10] suspended)
        else $error("short integration not caught");
    range_cfg_a: assert property ($rose(cfg_clock) |-> ##3 cap_range == cfg_reg[9:8])
        else $error("range does not follow config");
    cover property ($fell(data_ready_n));
    cover property ($rose(suspended));
    cover property ($fell(suspended));
endmodule
bind dis_seq dis_seq_properties #(.DR_TICKS(DR_TICKS), .MIN_TICKS(MIN_TICKS),
    .RECOV_TICKS(RECOV_TICKS)) chk_u (.mclk(mclk), .nrst(nrst),
    .integrate_toggle(integrate_toggle), .shift_clock(shift_clock), .cfg_data(cfg_data),
    .cfg_clock(cfg_clock), .int_a(int_a), .int_b(int_b), .integrate_toggle_a(integrate_toggle_a),
    .integrate_toggle_b(integrate_toggle_b), .prech_a(prech_a), .prech_b(prech_b), .cap_range(cap_range),
    .suspended(suspended), .data_ready_n(data_ready_n));
`default_nettype wire

// >>> verification/dis_ctl_model.sv
// Purpose: Controller model driving toggle, readout and config pins
// Assumes: The bench calls one task at a time
// Notes:   Config data idles at the inverse of its last bit
`default_nettype none
module dis_ctl_model (
    // Clock and status
    input  wire logic mclk,
    input  wire logic data_ready_n,
    // Pins toward the sequencer
    output var logic  integrate_toggle,
    output var logic  shift_clock,
    output var logic  cfg_data,
    output var logic  cfg_clock
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        integrate_toggle = 1'b0;
        shift_clock = 1'b0;
        cfg_data = 1'b0;
        cfg_clock = 1'b0;
    end
    task automatic flip();
        @(negedge mclk);
        integrate_toggle <= ~integrate_toggle;
    endtask
    // Shift clock pulses clear of toggle edges and rests low
    task automatic read_out();
        repeat (2) @(posedge mclk);
        shift_clock <= 1'b1;
        repeat (2) @(posedge mclk);
        shift_clock <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask
    task automatic write_cfg(input logic [15:0] word);
        for (int i = 15; i >= 0; i--) begin
            @(posedge mclk);
            cfg_data  <= word[i];
            cfg_clock <= 1'b0;
            repeat (4) @(posedge mclk);
            cfg_clock <= 1'b1;
            repeat (3) @(posedge mclk);
        end
        @(posedge mclk);
        cfg_clock <= 1'b0;
        cfg_data  <= ~word[0];
    endtask
endmodule
`default_nettype wire

// >>> verification/tb_dual_integrator_conversion_sequencer.sv
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Small tick parameters; clock runs free throughout
// Notes:   Each half except the 5-cycle one in t_violation is long enough for convert and precharge to end
`default_nettype none
module tb_dual_integrator_conversion_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DR = 20;
    logic       mclk = 1'b0;
    logic       nrst = 1'b0;
    logic       tog, sclk, cdat, cclk, susp, drdy_n;
    logic       int_a, int_b, integrate_toggle_a, integrate_toggle_b, prech_a, prech_b;
    logic [1:0] rng;
    int         miscompares = 0;
    int         num_checks = 0;
    always #50 mclk = ~mclk;
    dis_ctl_model ctl_u (.mclk(mclk), .data_ready_n(drdy_n), .integrate_toggle(tog),
        .shift_clock(sclk), .cfg_data(cdat), .cfg_clock(cclk));
    dis_seq #(.DR_TICKS(DR), .MIN_TICKS(10), .RECOV_TICKS(30)) dut_u (
        .mclk(mclk), .nrst(nrst), .integrate_toggle(tog), .shift_clock(sclk),
        .cfg_data(cdat), .cfg_clock(cclk), .int_a(int_a), .int_b(int_b),
        .integrate_toggle_a(integrate_toggle_a), .integrate_toggle_b(integrate_toggle_b), .prech_a(prech_a), .prech_b(prech_b),
        .cap_range(rng), .suspended(susp), .data_ready_n(drdy_n));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // One toggle edge: switch pattern, data ready timing and release
    task automatic step(input int hold, input int dr, input logic [2:0] exp);
        int n;
        ctl_u.flip();
        repeat (10) @(posedge mclk);
        check("int_a int_b integrate_toggle_a", {int_a, int_b, integrate_toggle_a}, exp);
        n = 10;
        while (dr > 0 && drdy_n !== 1'b0 && n < 900) begin
            @(posedge mclk);
            n++;
        end
        if (dr > 0) begin
            check("ready delay", n >= dr && n <= dr + 16, 1'b1);
            if (n >= 900) give_verdict();
            repeat (4) @(posedge mclk);
            check("ready held", drdy_n, 1'b0);
            ctl_u.read_out();
            check("ready released", drdy_n, 1'b1);
        end
        repeat (hold) @(posedge mclk);
        check("idle side settled", {integrate_toggle_a, prech_a, integrate_toggle_b, prech_b}, 4'h0);
    endtask
    task automatic t_range();
        for (int r = 0; r < 4; r++) begin
            ctl_u.write_cfg({6'h08, r[1:0], 8'h00});
            repeat (8) @(posedge mclk);
            check("cap_range", rng, r[1:0]);
        end
    endtask
    task automatic t_steady();
        for (int i = 0; i < 4; i++) step(1200, i > 0 ? DR : 0, i[0] ? 3'h3 : 3'h4);
    endtask
    task automatic t_slow();
        ctl_u.write_cfg(16'h0100);
        repeat (8) @(posedge mclk);
        check("slow range", rng, 2'h1);
        for (int i = 0; i < 2; i++) step(4600, 4 * DR, i[0] ? 3'h3 : 3'h4);
        ctl_u.write_cfg(16'h2000);
    endtask
    task automatic t_violation();
        step(1200, DR, 3'h4);
        ctl_u.flip();
        repeat (5) @(posedge mclk);
        ctl_u.flip();
        repeat (14) @(posedge mclk);
        check("suspended", susp, 1'b1);
        for (int i = 1; i <= 3; i++) begin
            repeat (1200) @(posedge mclk);
            ctl_u.read_out();
            ctl_u.flip();
            repeat (14) @(posedge mclk);
            check("suspended in recovery", susp, i < 3);
        end
        repeat (1200) @(posedge mclk);
        ctl_u.read_out();
        step(1200, DR, 3'h4);
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        check("reset outputs", {int_a, int_b, integrate_toggle_a, integrate_toggle_b, prech_a, prech_b, susp,
            drdy_n}, 8'h01);
        check("reset range", rng, 2'h0);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        t_range();
        t_steady();
        t_slow();
        t_violation();
        give_verdict();
    end
endmodule
`default_nettype wire
